// File: common/igec_pkg.sv
// igec_pkg: constants for the isolator gate enable control block.
// assumes a plain register port with one-cycle strobes and 16-bit data.
package igec_pkg;
    localparam int unsigned IGEC_NUM_DRV = 5;
    localparam int unsigned IGEC_ADDR_W = 4;
    localparam int unsigned IGEC_DATA_W = 16;
    // driver order inside every 5-bit group
    localparam int unsigned IGEC_DRV_U = 0;
    localparam int unsigned IGEC_DRV_V = 1;
    localparam int unsigned IGEC_DRV_W = 2;
    localparam int unsigned IGEC_DRV_BRG = 3;
    localparam int unsigned IGEC_DRV_REV = 4;
    // register addresses
    localparam logic [3:0] IGEC_CMD_ADDR = 4'h0;
    localparam logic [3:0] IGEC_CFG_ADDR = 4'h1;
    localparam logic [3:0] IGEC_STATE_ADDR = 4'h2;
    // command word: on bits [4:0], off bits [12:8]
    localparam int unsigned IGEC_ON_POS = 0;
    localparam int unsigned IGEC_OFF_POS = 8;
    // config word fields
    localparam int unsigned IGEC_CFG_SDS_POS = 0;
    localparam int unsigned IGEC_CFG_CGR_POS = 1;
    localparam int unsigned IGEC_CFG_SW_POS = 2;
    // state word: latched enables [4:0] (bit 4 is the reverse mosfet pin when source_drain_select is set), pending reverse off [8]
    localparam int unsigned IGEC_ST_PEND_POS = 8;
    localparam logic [4:0] IGEC_LATCH_RST = 5'h00;
    localparam logic [2:0] IGEC_CFG_RST = 3'h0;
    localparam logic [15:0] IGEC_RD_RST = 16'h0000;
    localparam int unsigned IGEC_SYNC_STAGES = 2;
    typedef enum logic [0:0] {
        IGEC_REV_IDLE,
        IGEC_REV_WAIT
    } igec_rev_state_type;
endpackage

// File: hw/igec_sync.sv
// igec_sync: two-flop synchroniser for a bus of level inputs.
// assumes each bit is a slow level; no event is carried across.
`timescale 1ns/1ps
module igec_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } igec_sync_state_type;

    igec_sync_state_type state_reg;
    igec_sync_state_type state_next;

    always_comb begin
        state_next.meta = async_in;
        state_next.stable = state_reg.meta;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.stable;
endmodule // igec_sync

// File: hw/igec_core.sv
// igec_core: enable latches and gate outputs for five isolator drivers.
// assumes an upstream serial front end presenting one-cycle strobes.
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module igec_core (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [4:0] protect_off_in,
    input wire logic neg_overcurrent_hit_in,
    input wire logic pump_good_in,
    input wire logic sleep_in,
    input wire logic reverse_mosfet_on_in,
    input wire logic gs_undervoltage_in,
    output logic [15:0] reg_rdata_out,
    output logic phase_u_gate_out,
    output logic phase_v_gate_out,
    output logic phase_w_gate_out,
    output logic bridge_gate_out,
    output logic reverse_gate_out,
    output logic divider_switch_output,
    output logic gs_fault_out
);
    // four pins from the analog side, synchronised before use; gs_undervoltage_in is used unsynchronised
    logic [3:0] raw_pins;
    logic [3:0] pins_sync;
    logic ocn_hit;
    logic pump_ok;
    logic sleep_s;
    logic rev_on_s;

    assign raw_pins = {reverse_mosfet_on_in, sleep_in, pump_good_in,
        neg_overcurrent_hit_in};

    igec_sync #(
        .WIDTH(4)
    ) u_sync (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .async_in(raw_pins),
        .sync_out(pins_sync)
    );

    assign ocn_hit = pins_sync[0];
    assign pump_ok = pins_sync[1];
    assign sleep_s = pins_sync[2];
    assign rev_on_s = pins_sync[3];

    typedef struct packed {
        logic [4:0] on_cmd;
        logic [4:0] off_cmd;
        logic cmd_valid;
        logic [4:0] driver_enable_latch;
        igec_pkg::igec_rev_state_type rev_state;
        logic source_drain_select;
        logic current_gated_reverse_off;
        logic divider_switch_on;
        logic [15:0] rdata;
        logic [4:0] gates;
        logic divider_sw;
        logic gs_fault;
    } igec_core_state_type;

    igec_core_state_type state_reg;
    igec_core_state_type state_next;

    logic [4:0] set_mask;
    logic [4:0] clr_mask;
    logic [4:0] latch_mid;
    logic [4:0] drive_lvl;
    logic [4:0] state_flag;

    // per-driver decode of the stored command pair
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_dec
            assign set_mask[gi] = state_reg.cmd_valid &
                state_reg.on_cmd[gi] & ~state_reg.off_cmd[gi];
            assign clr_mask[gi] = state_reg.cmd_valid &
                ~state_reg.on_cmd[gi] & state_reg.off_cmd[gi];
        end
    endgenerate

    always_comb begin
        state_next = state_reg;
        // command bits live one cycle then clear
        state_next.cmd_valid = 1'b0;
        state_next.on_cmd = 5'h00;
        state_next.off_cmd = 5'h00;
        if (reg_wr_in && reg_addr_in == igec_pkg::IGEC_CMD_ADDR) begin
            state_next.on_cmd = reg_wdata_in[4:0];
            state_next.off_cmd = reg_wdata_in[12:8];
            state_next.cmd_valid = 1'b1;
        end
        if (reg_wr_in && reg_addr_in == igec_pkg::IGEC_CFG_ADDR) begin
            state_next.source_drain_select =
                reg_wdata_in[igec_pkg::IGEC_CFG_SDS_POS];
            state_next.current_gated_reverse_off =
                reg_wdata_in[igec_pkg::IGEC_CFG_CGR_POS];
            state_next.divider_switch_on =
                reg_wdata_in[igec_pkg::IGEC_CFG_SW_POS];
        end

        // equal pairs touch neither mask, so latch holds
        latch_mid = (state_reg.driver_enable_latch | set_mask)
            & ~clr_mask;

        // reverse off may be held until negative current is seen
        state_next.rev_state = state_reg.rev_state;
        case (state_reg.rev_state)
            igec_pkg::IGEC_REV_IDLE: begin
                if (clr_mask[4] && state_reg.current_gated_reverse_off
                    && !ocn_hit) begin
                    latch_mid[4] = state_reg.driver_enable_latch[4];
                    state_next.rev_state = igec_pkg::IGEC_REV_WAIT;
                end
            end
            igec_pkg::IGEC_REV_WAIT: begin
                latch_mid[4] = state_reg.driver_enable_latch[4];
                if (set_mask[4]) begin
                    latch_mid[4] = 1'b1;
                    state_next.rev_state = igec_pkg::IGEC_REV_IDLE;
                end else if (ocn_hit ||
                    !state_reg.current_gated_reverse_off) begin
                    latch_mid[4] = 1'b0;
                    state_next.rev_state = igec_pkg::IGEC_REV_IDLE;
                end
            end
            default: begin
                state_next.rev_state = igec_pkg::IGEC_REV_IDLE;
            end
        endcase

        // protection clears win over every command
        state_next.driver_enable_latch = latch_mid & ~protect_off_in;
        if (protect_off_in[4]) begin
            state_next.rev_state = igec_pkg::IGEC_REV_IDLE;
        end

        // gates stay off while the pump is low, except reverse, which is on then if source_drain_select is set
        drive_lvl = state_reg.driver_enable_latch &
            {5{pump_ok}};
        // inversion done on the registered level, so it is glitch free
        drive_lvl[4] = drive_lvl[4] ^
            state_reg.source_drain_select;
        state_next.gates = drive_lvl;

        state_next.divider_sw = state_reg.divider_switch_on &
            ~sleep_s;
        state_next.gs_fault = gs_undervoltage_in &
            ~state_reg.source_drain_select;

        state_flag = state_reg.driver_enable_latch;
        if (state_reg.source_drain_select) begin
            state_flag[4] = rev_on_s;
        end

        state_next.rdata = igec_pkg::IGEC_RD_RST;
        if (reg_rd_in) begin
            case (reg_addr_in)
                igec_pkg::IGEC_CMD_ADDR: begin
                    state_next.rdata = igec_pkg::IGEC_RD_RST;
                end
                igec_pkg::IGEC_CFG_ADDR: begin
                    state_next.rdata = {13'h0000,
                        state_reg.divider_switch_on,
                        state_reg.current_gated_reverse_off,
                        state_reg.source_drain_select};
                end
                igec_pkg::IGEC_STATE_ADDR: begin
                    state_next.rdata = {7'h00,
                        state_reg.rev_state == igec_pkg::IGEC_REV_WAIT,
                        3'h0, state_flag};
                end
                default: begin
                    state_next.rdata = igec_pkg::IGEC_RD_RST;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            state_reg.on_cmd <= igec_pkg::IGEC_LATCH_RST;
            state_reg.off_cmd <= igec_pkg::IGEC_LATCH_RST;
            state_reg.cmd_valid <= 1'b0;
            state_reg.driver_enable_latch <= igec_pkg::IGEC_LATCH_RST;
            state_reg.rev_state <= igec_pkg::IGEC_REV_IDLE;
            state_reg.source_drain_select <= 1'b0;
            state_reg.current_gated_reverse_off <= 1'b0;
            state_reg.divider_switch_on <= 1'b0;
            state_reg.rdata <= igec_pkg::IGEC_RD_RST;
            state_reg.gates <= igec_pkg::IGEC_LATCH_RST;
            state_reg.divider_sw <= 1'b0;
            state_reg.gs_fault <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata_out = state_reg.rdata;
    assign phase_u_gate_out = state_reg.gates[0];
    assign phase_v_gate_out = state_reg.gates[1];
    assign phase_w_gate_out = state_reg.gates[2];
    assign bridge_gate_out = state_reg.gates[3];
    assign reverse_gate_out = state_reg.gates[4];
    assign divider_switch_output = state_reg.divider_sw;
    assign gs_fault_out = state_reg.gs_fault;

    // assertions
    a_on_sets_latch: assert property (@(posedge sys_clk_in)
        disable iff (!reset_n_in)
        (set_mask[0] && !protect_off_in[0])
        |=> state_reg.driver_enable_latch[0])
        else $error("on command did not set latch");

    a_off_clears_latch: assert property (@(posedge sys_clk_in)
        disable iff (!reset_n_in)
        clr_mask[1] |=> !state_reg.driver_enable_latch[1])
        else $error("off command did not clear latch");

    a_equal_keeps_latch: assert property (@(posedge sys_clk_in)
        disable iff (!reset_n_in)
        (state_reg.cmd_valid && state_reg.on_cmd[2] ==
        state_reg.off_cmd[2] && !protect_off_in[2])
        |=> $stable(state_reg.driver_enable_latch[2]))
        else $error("equal pair changed latch");

    a_cmd_self_clear: assert property (@(posedge sys_clk_in)
        disable iff (!reset_n_in)
        state_reg.cmd_valid |=> (!state_reg.cmd_valid ||
        $past(reg_wr_in)))
        else $error("command bits did not clear");

    a_cmd_next_cycle: assert property (@(posedge sys_clk_in)
        disable iff (!reset_n_in)
        (reg_wr_in && reg_addr_in == igec_pkg::IGEC_CMD_ADDR)
        |=> state_reg.cmd_valid)
        else $error("command not staged next cycle");

    a_rev_gated_hold: assert property (@(posedge sys_clk_in)
        disable iff (!reset_n_in)
        (state_reg.rev_state == igec_pkg::IGEC_REV_WAIT && !ocn_hit &&
        state_reg.current_gated_reverse_off && !set_mask[4] &&
        !protect_off_in[4]) |=> $stable(state_reg.driver_enable_latch[4]))
        else $error("reverse latch left while waiting");

    a_protect_clears: assert property (@(posedge sys_clk_in)
        disable iff (!reset_n_in)
        protect_off_in[3] |=> !state_reg.driver_enable_latch[3])
        else $error("protection did not clear latch");

    a_pump_gates_off: assert property (@(posedge sys_clk_in)
        disable iff (!reset_n_in)
        !pump_ok |=> !phase_u_gate_out && !bridge_gate_out)
        else $error("gate on without pump supply");

    a_sleep_switch_off: assert property (@(posedge sys_clk_in)
        disable iff (!reset_n_in)
        sleep_s |=> !divider_switch_output)
        else $error("divider switch on in sleep");

    a_rev_polarity: assert property (@(posedge sys_clk_in)
        disable iff (!reset_n_in)
        reverse_gate_out == ($past(state_reg.driver_enable_latch[4] &
        pump_ok) ^ $past(state_reg.source_drain_select)))
        else $error("reverse gate polarity wrong");

    a_fault_masked: assert property (@(posedge sys_clk_in)
        disable iff (!reset_n_in)
        state_reg.source_drain_select |=> !gs_fault_out)
        else $error("undervoltage fault not masked");
endmodule // igec_core

// File: dv/igec_host.sv
// igec_host: register bus master standing in for the serial host.
// assumes one-cycle strobes and read data in the cycle after the strobe.
`timescale 1ns/1ps
module igec_host (
    input wire logic sys_clk_in,
    input wire logic [15:0] rdata_in,
    output logic [3:0] addr_out,
    output logic [15:0] wdata_out,
    output logic wr_out,
    output logic rd_out
);
    initial begin
        addr_out = 4'h0;
        wdata_out = 16'h0000;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge sys_clk_in);
        wr_out <= 1'b0;
        // stale data must not look valid after the strobe
        wdata_out <= ~d;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge sys_clk_in);
        rd_out <= 1'b0;
        #1;
        d = rdata_in;
    endtask
endmodule // igec_host

// File: dv/isolator_gate_enable_control_test.sv
// isolator_gate_enable_control_test: self-checking bench for igec_core.
// assumes the host model drives the register port; 40 MHz clock.
`timescale 1ns/1ps
module isolator_gate_enable_control_test;
    logic sys_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic [4:0] protect_off_in = 5'h00;
    logic ocn_hit_in = 1'b0;
    logic pump_good_in = 1'b1;
    logic sleep_in = 1'b0;
    logic rev_mos_in = 1'b0;
    logic gs_uv_in = 1'b0;
    logic g_u, g_v, g_w, g_brg, g_rev, div_sw, gs_fault;
    logic [15:0] gates;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [15:0] rows_cmd [5] = '{16'h001F, 16'h0303, 16'h1A05, 16'h0012,
                                  16'h1F00};
    logic [15:0] rows_exp [5] = '{16'h001F, 16'h001F, 16'h0005, 16'h0017,
                                  16'h0000};

    assign gates = {11'h000, g_rev, g_brg, g_w, g_v, g_u};
    always #12.5 sys_clk_in = ~sys_clk_in;

    igec_core dut_u (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .protect_off_in(protect_off_in),
        .neg_overcurrent_hit_in(ocn_hit_in),
        .pump_good_in(pump_good_in), .sleep_in(sleep_in),
        .reverse_mosfet_on_in(rev_mos_in),
        .gs_undervoltage_in(gs_uv_in), .reg_rdata_out(reg_rdata),
        .phase_u_gate_out(g_u), .phase_v_gate_out(g_v),
        .phase_w_gate_out(g_w), .bridge_gate_out(g_brg),
        .reverse_gate_out(g_rev), .divider_switch_output(div_sw),
        .gs_fault_out(gs_fault)
    );

    igec_host host_u (
        .sys_clk_in(sys_clk_in), .rdata_in(reg_rdata),
        .addr_out(reg_addr), .wdata_out(reg_wdata),
        .wr_out(reg_wr), .rd_out(reg_rd)
    );

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_chk(input string what, input logic [3:0] a,
                          input logic [15:0] exp);
        logic [15:0] d;
        host_u.rd_reg(a, d);
        chk(what, exp, d);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // the whole run is under two hundred cycles; this only catches a hang
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            report_and_stop();
        end
    end

    initial begin
        settle(10);
        chk("gates in reset", 16'h0000, gates);
        chk("divider in reset", 16'h0000, {14'h0000, div_sw, gs_fault});
        reset_n_in <= 1'b1;
        settle(3);
        rd_chk("state after reset", pkg_state(), 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            host_u.wr_reg(igec_pkg::IGEC_CMD_ADDR, rows_cmd[i]);
            settle(2);
            chk("gates", rows_exp[i], gates);
            rd_chk("state", pkg_state(), rows_exp[i]);
            rd_chk("command readback", igec_pkg::IGEC_CMD_ADDR, 16'h0000);
        end
        rd_chk("unmapped read", 4'hF, 16'h0000);
        $display("test command table done");
        host_u.wr_reg(igec_pkg::IGEC_CMD_ADDR, 16'h001F);
        @(posedge sys_clk_in);
        pump_good_in <= 1'b0;
        settle(5);
        chk("gates without pump", 16'h0000, gates);
        rd_chk("latch without pump", pkg_state(), 16'h001F);
        @(posedge sys_clk_in);
        pump_good_in <= 1'b1;
        settle(5);
        chk("gates with pump", 16'h001F, gates);
        $display("test pump done");
        @(posedge sys_clk_in);
        protect_off_in <= 5'h01;
        @(posedge sys_clk_in);
        protect_off_in <= 5'h00;
        settle(4);
        chk("gates after protect", 16'h001E, gates);
        rd_chk("state after protect", pkg_state(), 16'h001E);
        $display("test protection done");
        @(posedge sys_clk_in);
        gs_uv_in <= 1'b1;
        rev_mos_in <= 1'b1;
        host_u.wr_reg(igec_pkg::IGEC_CFG_ADDR, 16'h0001);
        settle(4);
        chk("inverted reverse gate", 16'h000E, gates);
        chk("masked gs fault", 16'h0000, {15'h0000, gs_fault});
        rd_chk("mosfet state flag", pkg_state(), 16'h001E);
        @(posedge sys_clk_in);
        rev_mos_in <= 1'b0;
        settle(4);
        rd_chk("mosfet off flag", pkg_state(), 16'h000E);
        host_u.wr_reg(igec_pkg::IGEC_CFG_ADDR, 16'h0000);
        settle(4);
        chk("gs fault unmasked", 16'h0001, {15'h0000, gs_fault});
        chk("normal reverse gate", 16'h001E, gates);
        @(posedge sys_clk_in);
        gs_uv_in <= 1'b0;
        $display("test drain config done");
        host_u.wr_reg(igec_pkg::IGEC_CFG_ADDR, 16'h0002);
        host_u.wr_reg(igec_pkg::IGEC_CMD_ADDR, 16'h1000);
        settle(6);
        chk("reverse held", 16'h001E, gates);
        rd_chk("reverse pending", pkg_state(), 16'h011E);
        @(posedge sys_clk_in);
        ocn_hit_in <= 1'b1;
        settle(6);
        chk("reverse released", 16'h000E, gates);
        rd_chk("pending cleared", pkg_state(), 16'h000E);
        @(posedge sys_clk_in);
        ocn_hit_in <= 1'b0;
        $display("test gated reverse done");
        host_u.wr_reg(igec_pkg::IGEC_CFG_ADDR, 16'h0004);
        settle(3);
        chk("divider on", 16'h0001, {15'h0000, div_sw});
        @(posedge sys_clk_in);
        sleep_in <= 1'b1;
        settle(5);
        chk("divider in sleep", 16'h0000, {15'h0000, div_sw});
        @(posedge sys_clk_in);
        sleep_in <= 1'b0;
        settle(5);
        chk("divider after sleep", 16'h0001, {15'h0000, div_sw});
        host_u.wr_reg(igec_pkg::IGEC_CFG_ADDR, 16'h0000);
        settle(3);
        chk("divider off", 16'h0000, {15'h0000, div_sw});
        $display("test divider done");
        @(posedge sys_clk_in);
        reset_n_in <= 1'b0;
        settle(3);
        reset_n_in <= 1'b1;
        settle(3);
        chk("gates after reset", 16'h0000, gates);
        rd_chk("state after reset", pkg_state(), 16'h0000);
        $display("test second reset done");
        report_and_stop();
    end

    function automatic logic [3:0] pkg_state();
        return igec_pkg::IGEC_STATE_ADDR;
    endfunction
endmodule // isolator_gate_enable_control_test
